// *** logic/dim_pwm.v ***
// Fixed-frequency PWM with a duty given in whole percent.
// Assumes PERIOD is a multiple of 100 so each percent is an exact count.
`timescale 1ns/1ps
`default_nettype none

module dim_pwm #(
  parameter PERIOD = 250000
) (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  // Duty in percent, 0 to 100
  input  wire [6:0] duty_i,
  // PWM output, high for the duty share
  output reg        pwm_o
);

  localparam STEP = PERIOD / 100;

  reg  [31:0] cnt_r;
  wire [31:0] thr = {25'd0, duty_i} * STEP;

  // Free-running period counter; output registered to avoid glitches
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_r <= 32'h0;
      pwm_o <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 32'h0 : cnt_r + 32'h1;
      pwm_o <= (cnt_r < thr);
    end
  end

endmodule // dim_pwm

`default_nettype wire

// *** logic/load_defines.vh ***
// Constants for the load output, streetlight timer and transmit pin block.
// Assumes battery and panel voltages arrive already scaled to a 12 V system, in millivolts.
`ifndef LOAD_DEFINES_VH
`define LOAD_DEFINES_VH

// ****************************************
// Clock and time base
// ****************************************
`define CLK_HZ            40000000
`define SEC_CYCLES        (`CLK_HZ)
`define SEC_PER_MIN       6'd59
`define LOAD_DELAY_MIN    2
`define LOAD_DELAY_SEC    (`LOAD_DELAY_MIN * 60)
`define PULSE_MS          250
`define PULSE_CYCLES      (`CLK_HZ / 1000 * `PULSE_MS)
`define PWM_HZ            160
`define PWM_CYCLES        (`CLK_HZ / `PWM_HZ)
`define RX_IDLE_US        2000
`define RX_HOLD_CYCLES    (`CLK_HZ / 1000000 * `RX_IDLE_US)

// ****************************************
// Load programs and thresholds (mV)
// ****************************************
`define PRG_OFF           3'h0
`define PRG_ADAPT         3'h1
`define PRG_FIX1          3'h2
`define PRG_FIX2          3'h3
`define PRG_ON            3'h4
`define PRG_USER1         3'h5
`define PRG_USER2         3'h6
`define PRG_TIMED         3'h7
`define FIX1_LO_MV        16'h2b5c
`define FIX1_HI_MV        16'h332c
`define FIX2_LO_MV        16'h2e18
`define FIX2_HI_MV        16'h36b0
`define ADAPT_LO_MV       16'h2c88
`define ADAPT_HI_MV       16'h339a

// ****************************************
// Streetlight timing and detection
// ****************************************
`define SUNSET_NONE       2'h0
`define SUNSET_HOURS      2'h1
`define SUNSET_MIDNIGHT   2'h2
`define SUNSET_TO_RISE    2'h3
`define ASSUMED_NIGHT_MIN 11'h2d0
`define ASSUMED_MID_MIN   11'h168
`define SYNC_DAYS         3'h5
`define NIGHT_MIN_MV      16'h2c88
`define DAY_MARGIN_MV     16'h01f4
`define DIM_FULL          7'h64

// ****************************************
// Transmit pin modes
// ****************************************
`define TX_SERIAL         3'h0
`define TX_PULSE          3'h1
`define TX_PWM            3'h2
`define TX_PWM_INV        3'h3
`define TX_VLOAD          3'h4

`endif

// *** logic/load_output_streetlight_tx.v ***
// Load output switch, streetlight scheduler and multi-function transmit pin.
// Assumes voltages are normalised to a 12 V system, settings come from a retained store.
//
// Overview of operation
// - Eight load programs selected by program input
// - Fixed program one: off 11.10V, on 13.10V
// - Fixed program two: off 11.80V, on 14.00V
// - User program one: hysteresis between user thresholds
// - User program two: on only inside band
// - Timed program: thresholds, then on for duration
// - Sensing programs wait two minutes; on, off immediate
// - Low battery overrides streetlight, schedule resumes afterwards
// - Switch closed only when load on, dim nonzero
// - Assume 12h nights until five synced days
// - Sunset action: none, hours, midnight, or sunrise
// - Sunrise action: off, or on hours before sunrise
// - Timer program lives in non-volatile settings store
// - Midnight shifted by signed minutes, zero none
// - Day level 0.5V above night, 11.4V floor
// - Day/night changeover waits 0 to 60 minutes
// - Dim ramp 0 to 99 seconds per point
// - Transmit pin modes: serial, pulse, PWM, virtual load
// - Energy pulse drives pin low about 250ms
// - Dimming PWM at 160Hz, normal or inverted
// - Virtual load mode mirrors load decision
// - Incoming serial data restores normal communication temporarily
`include "load_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module load_output_streetlight_tx #(
  parameter SEC_CYCLES     = `SEC_CYCLES,
  parameter PULSE_CYCLES   = `PULSE_CYCLES,
  parameter PWM_CYCLES     = `PWM_CYCLES,
  parameter RX_HOLD_CYCLES = `RX_HOLD_CYCLES
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  // Measurements, millivolts
  input  wire [15:0] batt_mv_i,
  input  wire [15:0] panel_mv_i,
  // Load program settings
  input  wire [2:0]  program_i,
  input  wire [15:0] user_lo_mv_i,
  input  wire [15:0] user_hi_mv_i,
  input  wire [9:0]  timed_minutes_i,
  // Streetlight settings
  input  wire [1:0]  sunset_action_i,
  input  wire [3:0]  sunset_hours_i,
  input  wire [6:0]  dim_on_i,
  input  wire [6:0]  dim_end_i,
  input  wire        sunrise_pre_i,
  input  wire [3:0]  sunrise_hours_i,
  input  wire [6:0]  dim_rise_i,
  input  wire [10:0] mid_shift_i,
  input  wire [15:0] night_mv_i,
  input  wire [5:0]  daynight_delay_i,
  input  wire [6:0]  ramp_speed_i,
  // Transmit pin settings and sources
  input  wire [2:0]  tx_mode_i,
  input  wire        energy_tick_i,
  input  wire        serial_tx_i,
  input  wire        rx_pin_i,
  // Outputs
  output reg         load_switch_o,
  output wire        load_decision_o,
  output wire [6:0]  dim_level_o,
  output wire        is_night_o,
  output wire        synced_o,
  output reg         tx_o
);

  // ****************************************
  // Time base
  // ****************************************
  localparam [6:0] LOAD_DELAY = `LOAD_DELAY_SEC;

  reg  [31:0] sec_cnt_r;
  reg  [5:0]  sec_of_min_r;
  wire        sec_tick = (sec_cnt_r == SEC_CYCLES - 1);
  wire        min_tick = sec_tick && (sec_of_min_r == `SEC_PER_MIN);

  // Second and minute pulses shared by every slow timer
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sec_cnt_r    <= 32'h0;
      sec_of_min_r <= 6'h0;
    end else begin
      sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
      if (sec_tick) begin
        sec_of_min_r <= min_tick ? 6'h0 : sec_of_min_r + 6'h1;
      end
    end
  end

  // ****************************************
  // Load program decision
  // ****************************************
  reg        load_r;
  reg        want_on;
  reg        sensing;
  reg [15:0] thr_lo;
  reg [15:0] thr_hi;

  // Threshold pair and wanted state per program
  always @* begin
    thr_lo  = user_lo_mv_i;
    thr_hi  = user_hi_mv_i;
    sensing = 1'b1;
    want_on = load_r;
    if (program_i == `PRG_FIX1) begin
      thr_lo = `FIX1_LO_MV;
      thr_hi = `FIX1_HI_MV;
    end else if (program_i == `PRG_FIX2) begin
      thr_lo = `FIX2_LO_MV;
      thr_hi = `FIX2_HI_MV;
    end else if (program_i == `PRG_ADAPT) begin
      thr_lo = `ADAPT_LO_MV;
      thr_hi = `ADAPT_HI_MV;
    end
    case (program_i)
      `PRG_OFF: begin
        want_on = 1'b0;
        sensing = 1'b0;
      end
      `PRG_ON: begin
        want_on = 1'b1;
        sensing = 1'b0;
      end
      `PRG_USER2: begin
        want_on = (batt_mv_i >= thr_lo) && (batt_mv_i <= thr_hi);
      end
      default: begin
        // Hysteresis: state held between the two thresholds
        if (batt_mv_i < thr_lo) begin
          want_on = 1'b0;
        end else if (batt_mv_i > thr_hi) begin
          want_on = 1'b1;
        end
      end
    endcase
  end

  wire load_done;

  // Sensing programs must see the change persist, so inrush dips are ignored
  persist_timer #(
    .W (7)
  ) u_load_delay (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .cond_i    (want_on != load_r),
    .tick_i    (sec_tick),
    .limit_i   (sensing ? LOAD_DELAY : 7'h0),
    .done_o    (load_done)
  );

  reg        timed_run_r;
  reg [9:0]  timed_min_r;

  // Qualified load state, and the on-time window of the timed program
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      load_r      <= 1'b0;
      timed_run_r <= 1'b0;
      timed_min_r <= 10'h0;
    end else begin
      if (load_done) begin
        load_r <= want_on;
      end
      if (load_done && want_on) begin
        timed_run_r <= 1'b1;
        timed_min_r <= timed_minutes_i;
      end else if (!load_r || (timed_run_r && timed_min_r == 10'h0)) begin
        timed_run_r <= 1'b0;
      end else if (min_tick && timed_min_r != 10'h0) begin
        timed_min_r <= timed_min_r - 10'h1;
      end
    end
  end

  assign load_decision_o = (program_i == `PRG_TIMED) ? (load_r && timed_run_r) : load_r;

  // ****************************************
  // Day and night detection
  // ****************************************
  reg         night_r;
  wire [15:0] night_thr = ((night_mv_i == 16'h0) || (night_mv_i < `NIGHT_MIN_MV)) ?
                          `NIGHT_MIN_MV : night_mv_i;
  wire [15:0] day_thr   = night_thr + `DAY_MARGIN_MV;
  wire        dn_done;

  // One timer serves both directions; the pending edge depends on the state
  persist_timer #(
    .W (7)
  ) u_dn_delay (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .cond_i    (night_r ? (panel_mv_i > day_thr) : (panel_mv_i < night_thr)),
    .tick_i    (min_tick),
    .limit_i   ({1'b0, daynight_delay_i}),
    .done_o    (dn_done)
  );

  wire sunset  = dn_done && !night_r;
  wire sunrise = dn_done && night_r;

  // ****************************************
  // Solar clock learning
  // ****************************************
  reg [10:0] since_r;
  reg [10:0] night_len_r;
  reg [2:0]  days_r;
  wire       synced = (days_r == `SYNC_DAYS);

  // Night length learned at each sunrise; resetting restarts the learning
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      night_r     <= 1'b0;
      since_r     <= 11'h0;
      night_len_r <= `ASSUMED_NIGHT_MIN;
      days_r      <= 3'h0;
    end else begin
      if (dn_done) begin
        night_r <= !night_r;
      end
      if (sunset) begin
        since_r <= 11'h0;
      end else if (min_tick && since_r != 11'h7ff) begin
        since_r <= since_r + 11'h1;
      end
      if (sunrise) begin
        night_len_r <= since_r;
        if (!synced) begin
          days_r <= days_r + 3'h1;
        end
      end
    end
  end

  // ****************************************
  // Schedule target
  // ****************************************
  wire [10:0] night_len = synced ? night_len_r : `ASSUMED_NIGHT_MIN;
  wire [10:0] mid_base  = synced ? {1'b0, night_len_r[10:1]} : `ASSUMED_MID_MIN;
  wire [11:0] mid_sum   = {1'b0, mid_base} + {mid_shift_i[10], mid_shift_i};
  wire [10:0] midnight  = (mid_shift_i[10] && mid_sum[11]) ? 11'h0 : mid_sum[10:0];
  wire [10:0] set_span  = {7'h0, sunset_hours_i} * 11'd60;
  wire [10:0] rise_span = {7'h0, sunrise_hours_i} * 11'd60;
  wire [10:0] pre_start = (rise_span > night_len) ? 11'h0 : night_len - rise_span;

  reg [6:0] target;

  // Scheduled level during the night; daytime is always dark.
  // The settings come straight from the retained store; the learned night length and synced days restart on power loss.
  always @* begin
    target = 7'h0;
    if (night_r) begin
      case (sunset_action_i)
        `SUNSET_HOURS:    target = (since_r < set_span) ? dim_on_i : dim_end_i;
        `SUNSET_MIDNIGHT: target = (since_r < midnight) ? dim_on_i : dim_end_i;
        `SUNSET_TO_RISE:  target = dim_on_i;
        default:          target = 7'h0;
      endcase
      if (sunset_action_i != `SUNSET_TO_RISE && sunrise_pre_i && since_r >= pre_start) begin
        target = dim_rise_i;
      end
      if (target > `DIM_FULL) begin
        target = `DIM_FULL;
      end
    end
  end

  // ****************************************
  // Gradual dimming
  // ****************************************
  reg [6:0] dim_r;
  reg [6:0] ramp_cnt_r;

  // One percentage point per interval keeps the level an integer
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      dim_r      <= 7'h0;
      ramp_cnt_r <= 7'h0;
    end else if (ramp_speed_i == 7'h0 || dim_r == target) begin
      dim_r      <= target;
      ramp_cnt_r <= 7'h0;
    end else if (sec_tick) begin
      if (ramp_cnt_r + 7'h1 >= ramp_speed_i) begin
        ramp_cnt_r <= 7'h0;
        dim_r      <= (dim_r < target) ? dim_r + 7'h1 : dim_r - 7'h1;
      end else begin
        ramp_cnt_r <= ramp_cnt_r + 7'h1;
      end
    end
  end

  // Low battery opens the switch whatever the schedule asks; lights return with it
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      load_switch_o <= 1'b0;
    end else begin
      load_switch_o <= load_decision_o && (dim_r != 7'h0);
    end
  end

  // ****************************************
  // Transmit pin sources
  // ****************************************
  wire pwm;

  dim_pwm #(
    .PERIOD (PWM_CYCLES)
  ) u_pwm (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .duty_i    (dim_r),
    .pwm_o     (pwm)
  );

  reg [31:0] pulse_cnt_r;

  // Each energy quantum restarts a fixed low pulse
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pulse_cnt_r <= 32'h0;
    end else if (energy_tick_i) begin
      pulse_cnt_r <= PULSE_CYCLES;
    end else if (pulse_cnt_r != 32'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 32'h1;
    end
  end

  reg        rx_meta_r;
  reg        rx_sync_r;
  reg [31:0] rx_hold_r;

  // Receive pin synchronised; any low bit keeps normal serial for a hold time
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_hold_r <= 32'h0;
    end else begin
      rx_meta_r <= rx_pin_i;
      rx_sync_r <= rx_meta_r;
      if (!rx_sync_r) begin
        rx_hold_r <= RX_HOLD_CYCLES;
      end else if (rx_hold_r != 32'h0) begin
        rx_hold_r <= rx_hold_r - 32'h1;
      end
    end
  end

  // Pin mux; an idle line reads high
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tx_o <= 1'b1;
    end else if (rx_hold_r != 32'h0) begin
      tx_o <= serial_tx_i;
    end else begin
      case (tx_mode_i)
        `TX_PULSE:   tx_o <= (pulse_cnt_r == 32'h0);
        `TX_PWM:     tx_o <= pwm;
        `TX_PWM_INV: tx_o <= !pwm;
        `TX_VLOAD:   tx_o <= load_decision_o;
        default:     tx_o <= serial_tx_i;
      endcase
    end
  end

  assign dim_level_o = dim_r;
  assign is_night_o  = night_r;
  assign synced_o    = synced;

endmodule // load_output_streetlight_tx

`default_nettype wire

// *** logic/persist_timer.v ***
// Qualifies a condition: done only after it has held for a number of ticks.
// Assumes tick_i is a one-cycle pulse on clk_sys_i; a limit of zero qualifies at once.
`timescale 1ns/1ps
`default_nettype none

module persist_timer #(
  parameter W = 7
) (
  // Clock and reset
  input  wire         clk_sys_i,
  input  wire         resetn_i,
  // Condition and time base
  input  wire         cond_i,
  input  wire         tick_i,
  input  wire [W-1:0] limit_i,
  // Qualified result
  output wire         done_o
);

  reg [W-1:0] cnt_r;

  // Result is combinational so the owner can act in the same cycle
  assign done_o = cond_i && ((limit_i == {W{1'b0}}) || (cnt_r >= limit_i));

  // Any break in the condition restarts the wait
  always @(posedge clk_sys_i) begin
    if (!resetn_i || !cond_i || done_o) begin
      cnt_r <= {W{1'b0}};
    end else if (tick_i) begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // persist_timer

`default_nettype wire

// *** sim/load_output_streetlight_tx_checker.sv ***
// Port assertions for the load output, streetlight and transmit pin block.
// Assumes one clock domain; bound to the design by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none
`include "load_defines.vh"

module load_output_streetlight_tx_checker #(
  parameter PULSE_CYCLES   = 20,
  parameter PWM_CYCLES     = 1000,
  parameter RX_HOLD_CYCLES = 50
) (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  // Watched inputs
  input wire logic [15:0] batt_mv_i,
  input wire logic [2:0]  program_i,
  input wire logic [2:0]  tx_mode_i,
  input wire logic        energy_tick_i,
  input wire logic        serial_tx_i,
  input wire logic        rx_pin_i,
  // Watched outputs
  input wire logic        load_switch_o,
  input wire logic        load_decision_o,
  input wire logic [6:0]  dim_level_o,
  input wire logic        tx_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // ****************************************
  // Helper ages
  // ****************************************
  logic [19:0] rx_age_r;
  logic [19:0] tick_age_r;
  logic [19:0] full_age_r;
  logic        quiet;
  // Ages restart at reset so nothing counts as settled too early
  always @(posedge clk_sys_i) begin
    rx_age_r   <= (!resetn_i || !rx_pin_i) ? 20'h0 : rx_age_r + {19'h0, ~&rx_age_r};
    tick_age_r <= (!resetn_i || energy_tick_i) ? 20'h0 : tick_age_r + {19'h0, ~&tick_age_r};
    full_age_r <= (!resetn_i || dim_level_o != `DIM_FULL) ? 20'h0 :
                  full_age_r + {19'h0, ~&full_age_r};
  end
  assign quiet = (rx_age_r > RX_HOLD_CYCLES + 4);

  // ****************************************
  // Assertions
  // ****************************************
  AST_RESET_VALUES: assert property (disable iff (1'b0) !resetn_i |=>
    (!load_switch_o && !load_decision_o && tx_o && dim_level_o == 7'h00))
    else $error("outputs not at reset values");
  AST_ALWAYS_ON: assert property ((program_i == `PRG_ON)[*3] |-> load_decision_o)
    else $error("always-on program not applied");
  AST_ALWAYS_OFF: assert property ((program_i == `PRG_OFF)[*3] |-> !load_decision_o)
    else $error("always-off program not applied");
  AST_SWITCH_OPEN: assert property ((!load_decision_o || dim_level_o == 7'h00) |=>
    !load_switch_o) else $error("switch closed without decision or dim");
  AST_SWITCH_CLOSE: assert property ((load_decision_o && dim_level_o != 7'h00)[*2] |->
    ##[0:1] load_switch_o) else $error("switch open with decision and dim");
  AST_FIX1_ON: assert property ($rose(load_decision_o) && program_i == `PRG_FIX1 &&
    $past(program_i) == `PRG_FIX1 |-> $past(batt_mv_i) > `FIX1_HI_MV)
    else $error("fixed program one on below its upper level");
  AST_PWM_FULL: assert property ((quiet && tx_mode_i == `TX_PWM &&
    full_age_r > 2 * PWM_CYCLES)[*2] |-> tx_o) else $error("full duty PWM not high");
  AST_PULSE_LOW: assert property (quiet && tx_mode_i == `TX_PULSE && energy_tick_i
    ##1 tx_mode_i == `TX_PULSE |-> ##1 (!tx_o)[*8]) else $error("energy pulse not low");
  AST_PULSE_IDLE: assert property ((quiet && tx_mode_i == `TX_PULSE &&
    tick_age_r > PULSE_CYCLES + 4)[*3] |-> tx_o) else $error("pulse pin not idle high");
  AST_VLOAD: assert property ((quiet && tx_mode_i == `TX_VLOAD)[*2] |->
    tx_o == $past(load_decision_o)) else $error("virtual load pin off decision");
  AST_RX_SERIAL: assert property ((!rx_pin_i)[*4] |=> tx_o == $past(serial_tx_i))
    else $error("serial data not passed during reception");

  // Main scenarios reached
  cover property ($rose(load_switch_o));
  cover property (tx_mode_i == `TX_PULSE && $fell(tx_o));
  cover property (!rx_pin_i && tx_mode_i != `TX_SERIAL);
endmodule // load_output_streetlight_tx_checker

bind load_output_streetlight_tx load_output_streetlight_tx_checker #(
  .PULSE_CYCLES(PULSE_CYCLES), .PWM_CYCLES(PWM_CYCLES), .RX_HOLD_CYCLES(RX_HOLD_CYCLES)
) u_chk (.clk_sys_i, .resetn_i, .batt_mv_i, .program_i, .tx_mode_i, .energy_tick_i,
  .serial_tx_i, .rx_pin_i, .load_switch_o, .load_decision_o, .dim_level_o, .tx_o);
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the load output, streetlight and transmit pin block.
// Assumes the checker binds itself; short parameters stand in for long times.
`timescale 1ns/1ps
`default_nettype none
`include "load_defines.vh"
`define CHK(g, e) begin #2; cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  localparam PULSE = 20;
  localparam PWM   = 1000;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, sunrise_pre_i = 1'b0;
  logic energy_tick_i = 1'b0, serial_tx_i = 1'b1, rx_pin_i = 1'b1, clr = 1'b0;
  logic [15:0] batt_mv_i = 16'h2ee0, panel_mv_i = 16'h0000, night_mv_i = 16'h0000;
  logic [15:0] user_lo_mv_i = 16'h2ee0, user_hi_mv_i = 16'h32c8;
  logic [2:0]  program_i = `PRG_OFF, tx_mode_i = `TX_SERIAL;
  logic [9:0]  timed_minutes_i = 10'h003;
  logic [1:0]  sunset_action_i = `SUNSET_TO_RISE;
  logic [3:0]  sunset_hours_i = 4'h1, sunrise_hours_i = 4'h1;
  logic [6:0]  dim_on_i = 7'h64, dim_end_i = 7'h32, dim_rise_i = 7'h64, ramp_speed_i = 7'h00;
  logic [10:0] mid_shift_i = 11'h000;
  logic [5:0]  daynight_delay_i = 6'h00;
  logic        load_switch_o, load_decision_o, is_night_o, synced_o, tx_o;
  logic [6:0]  dim_level_o;
  logic [15:0] low, falls;
  int          fails = 0, cmp_count = 0;

  load_output_streetlight_tx #(.SEC_CYCLES(40), .PULSE_CYCLES(PULSE), .PWM_CYCLES(PWM),
    .RX_HOLD_CYCLES(50)) dut (.clk_sys_i, .resetn_i, .batt_mv_i, .panel_mv_i, .program_i,
    .user_lo_mv_i, .user_hi_mv_i, .timed_minutes_i, .sunset_action_i, .sunset_hours_i,
    .dim_on_i, .dim_end_i, .sunrise_pre_i, .sunrise_hours_i, .dim_rise_i, .mid_shift_i,
    .night_mv_i, .daynight_delay_i, .ramp_speed_i, .tx_mode_i, .energy_tick_i,
    .serial_tx_i, .rx_pin_i, .load_switch_o, .load_decision_o, .dim_level_o, .is_night_o,
    .synced_o, .tx_o);
  tx_sink_model sink (.clk_sys_i, .tx_i(tx_o), .clr_i(clr), .low_o(low), .falls_o(falls));

  // 40 MHz system clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic wc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Restart the sink window, then let n samples accumulate
  task automatic window(input int n);
    @(posedge clk_sys_i); clr <= 1'b1;
    @(posedge clk_sys_i); clr <= 1'b0;
    wc(n);
  endtask
  // Sensing step: wait past the two-minute persistence, then judge
  task automatic step(input logic [2:0] p, input logic [15:0] b, input logic e);
    @(posedge clk_sys_i); program_i <= p; batt_mv_i <= b;
    wc(4900);
    `CHK(load_decision_o, e)
    `CHK(load_switch_o, e)
  endtask
  task automatic set_prog(input logic [2:0] p);
    @(posedge clk_sys_i); program_i <= p;
    wc(3);
  endtask
  task automatic pwm(input logic [2:0] m, input logic [15:0] e);
    @(posedge clk_sys_i); tx_mode_i <= m;
    wc(1100); window(PWM);
    `CHK(low, e)
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_programs;
    set_prog(`PRG_ON); `CHK(load_switch_o, 1'b1)
    set_prog(`PRG_OFF); `CHK(load_decision_o, 1'b0)
    @(posedge clk_sys_i); program_i <= `PRG_FIX1; batt_mv_i <= 16'h3390;
    wc(4760); `CHK(load_decision_o, 1'b0)
    wc(140); `CHK(load_decision_o, 1'b1)
    step(`PRG_FIX1, 16'h2ee0, 1'b1);
    step(`PRG_FIX1, 16'h2af8, 1'b0);
    step(`PRG_FIX2, 16'h34bc, 1'b0);
    step(`PRG_FIX2, 16'h3714, 1'b1);
    step(`PRG_FIX2, 16'h2db4, 1'b0);
    step(`PRG_USER1, 16'h3318, 1'b1);
    step(`PRG_USER1, 16'h30d4, 1'b1);
    step(`PRG_USER1, 16'h2e7c, 1'b0);
    step(`PRG_USER2, 16'h30d4, 1'b1);
    step(`PRG_USER2, 16'h3318, 1'b0);
    step(`PRG_TIMED, 16'h3318, 1'b1);
    wc(7300); `CHK(load_decision_o, 1'b0)
    $display("test programs done");
  endtask

  task automatic t_daynight;
    set_prog(`PRG_ON);
    `CHK(synced_o, 1'b0)
    repeat (5) begin
      @(posedge clk_sys_i); panel_mv_i <= 16'h2ee0; wc(3);
      @(posedge clk_sys_i); panel_mv_i <= 16'h2c24; wc(3);
    end
    `CHK(synced_o, 1'b1)
    @(posedge clk_sys_i); panel_mv_i <= 16'h2e18; wc(3);
    `CHK(is_night_o, 1'b1)
    @(posedge clk_sys_i); panel_mv_i <= 16'h2ee0; wc(4);
    `CHK(is_night_o, 1'b0)
    `CHK({load_switch_o, dim_level_o}, 8'h00)
    @(posedge clk_sys_i); panel_mv_i <= 16'h2e18; ramp_speed_i <= 7'h01; dim_on_i <= 7'h0a;
    wc(3); `CHK(is_night_o, 1'b0)
    @(posedge clk_sys_i); panel_mv_i <= 16'h2c24; wc(200);
    `CHK(dim_level_o >= 7'h03 && dim_level_o <= 7'h06, 1'b1)
    wc(300); `CHK(dim_level_o, 7'h0a)
    // Learned night is near zero, so solar midnight falls at the shift alone
    @(posedge clk_sys_i); sunset_action_i <= `SUNSET_MIDNIGHT; mid_shift_i <= 11'h002;
    ramp_speed_i <= 7'h00; wc(3); `CHK(dim_level_o, 7'h0a)
    wc(5000); `CHK(dim_level_o, 7'h32)
    @(posedge clk_sys_i); sunrise_pre_i <= 1'b1; dim_rise_i <= 7'h46; wc(3);
    `CHK(dim_level_o, 7'h46)
    @(posedge clk_sys_i); sunset_action_i <= `SUNSET_TO_RISE; mid_shift_i <= 11'h000;
    sunrise_pre_i <= 1'b0; dim_rise_i <= 7'h64;
    $display("test day and night done");
  endtask

  task automatic t_pin;
    pwm(`TX_PWM, 16'd900);
    pwm(`TX_PWM_INV, 16'd100);
    @(posedge clk_sys_i); ramp_speed_i <= 7'h00; dim_on_i <= 7'h64;
    pwm(`TX_PWM_INV, 16'd1000);
    pwm(`TX_PWM, 16'd0);
    @(posedge clk_sys_i); tx_mode_i <= `TX_PULSE; wc(60);
    @(posedge clk_sys_i); clr <= 1'b1; energy_tick_i <= 1'b1;
    @(posedge clk_sys_i); clr <= 1'b0; energy_tick_i <= 1'b0; wc(40);
    `CHK(falls, 16'h0001)
    `CHK(low == PULSE || low == PULSE + 1, 1'b1)
    @(posedge clk_sys_i); tx_mode_i <= `TX_VLOAD; wc(3); `CHK(tx_o, 1'b1)
    set_prog(`PRG_OFF); `CHK(tx_o, 1'b0)
    @(posedge clk_sys_i); tx_mode_i <= `TX_PULSE; serial_tx_i <= 1'b0; rx_pin_i <= 1'b0;
    wc(10); `CHK(tx_o, 1'b0)
    @(posedge clk_sys_i); rx_pin_i <= 1'b1; wc(20); `CHK(tx_o, 1'b0)
    wc(60); `CHK(tx_o, 1'b1)
    $display("test transmit pin done");
  endtask

  // Main sequence
  initial begin
    wc(15);
    @(posedge clk_sys_i); resetn_i <= 1'b1;
    `CHK({tx_o, load_switch_o, dim_level_o}, 9'h100)
    t_programs();
    t_daynight();
    t_pin();
    final_report();
  end

  // Hang guard sized above the longest expected run
  initial begin
    wc(98000);
    fails++;
    final_report();
  end
endmodule // testbench
`default_nettype wire

// *** sim/tx_sink_model.sv ***
// Far-side model on the transmit pin: an energy meter or LED driver input.
// Assumes the pin is sampled on the system clock; counts low cycles and falls.
`timescale 1ns/1ps
`default_nettype none

module tx_sink_model (
  // Clock and pin
  input  wire logic        clk_sys_i,
  input  wire logic        tx_i,
  // Window restart
  input  wire logic        clr_i,
  // Observations
  output var logic [15:0]  low_o,
  output var logic [15:0]  falls_o
);
  logic prev_r = 1'b1;
  // A meter counts falling edges, a driver integrates the low share
  always @(posedge clk_sys_i) begin
    prev_r <= tx_i;
    if (clr_i) begin
      low_o   <= 16'h0000;
      falls_o <= 16'h0000;
    end else begin
      if (!tx_i) low_o <= low_o + 16'h0001;
      if (prev_r && !tx_i) falls_o <= falls_o + 16'h0001;
    end
  end
endmodule // tx_sink_model
`default_nettype wire
